//--- logic/mju_pkg.sv
package mju_pkg;
  // ----------------------------------------------------------
  // register index space (byte address = 4 * index)
  // ----------------------------------------------------------
  localparam int IDX_W = 18;
  localparam int ADDR_W = IDX_W + 2;
  localparam logic [IDX_W-1:0] IDX_POS_UNIT = 18'h060A8;
  localparam logic [IDX_W-1:0] IDX_VEL_UNIT = 18'h060A9;
  localparam logic [IDX_W-1:0] IDX_POS_OFF = 18'h060B0;
  localparam logic [IDX_W-1:0] IDX_SPD_OFF = 18'h060B1;
  localparam logic [IDX_W-1:0] IDX_JF_COUNT = 18'h06100;
  localparam logic [IDX_W-1:0] IDX_JF_TOP = 18'h06101;
  localparam logic [IDX_W-1:0] IDX_JF_BOTTOM = 18'h06102;
  localparam logic [IDX_W-1:0] IDX_JL_COUNT = 18'h06104;
  localparam logic [IDX_W-1:0] IDX_JL_BASE = 18'h06105;
  localparam int JERK_PHASES = 4;

  // ----------------------------------------------------------
  // reset values and entry counts
  // ----------------------------------------------------------
  localparam logic [31:0] RST_JERK = 32'h000003E8;
  localparam logic [31:0] RST_FACTOR = 32'h00000001;
  localparam logic [31:0] RST_POS_UNIT = 32'hFF410000;
  localparam logic [31:0] RST_VEL_UNIT = 32'h00B44700;
  localparam logic [31:0] RST_OFFSET = 32'h00000000;
  localparam logic [7:0] JF_ENTRIES = 8'h02;
  localparam logic [7:0] JL_ENTRIES = 8'h04;

  // ----------------------------------------------------------
  // unit word fields
  // ----------------------------------------------------------
  localparam int EXP_LSB = 24;
  localparam int POS_CODE_LSB = 16;
  localparam int TIME_CODE_LSB = 8;
  localparam logic [31:0] POS_UNIT_MASK = 32'hFFFFFFFF << POS_CODE_LSB;
  localparam logic [31:0] VEL_UNIT_MASK = 32'hFFFFFFFF << TIME_CODE_LSB;

  // ----------------------------------------------------------
  // operating mode codes and bus responses
  // ----------------------------------------------------------
  localparam logic [7:0] MODE_CSP = 8'h08;
  localparam logic [7:0] MODE_CSV = 8'h09;
  localparam logic [7:0] MODE_CLKDIR = 8'hFF;
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;
endpackage

//--- logic/mju_param_bank.sv
`timescale 1ns/1ps
// Overview of operation
// - zero jerk entry means unlimited jerk
// - subindex 1,2 begin jerks, preset 3E8
// - subindex 3,4 end jerks; count reads four
// - jerk factor numerator/denominator, preset one, count two
// - position unit word fields, low half zero
// - velocity unit word fields, low byte zero
// - position offset added only in csp
// - speed offset added in csp, csv, clock-dir
module mju_param_bank
  import mju_pkg::*;
(
  // clock, reset, enable
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic ce,
  // axi4-lite write address
  input wire logic [ADDR_W-1:0] s_axi_awaddr,
  input wire logic [2:0] s_axi_awprot,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  // axi4-lite write data
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  // axi4-lite write response
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  // axi4-lite read address
  input wire logic [ADDR_W-1:0] s_axi_araddr,
  input wire logic [2:0] s_axi_arprot,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  // axi4-lite read data
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  // set value path
  input wire logic [7:0] op_mode,
  input wire logic [31:0] pos_setpoint,
  input wire logic [31:0] spd_setpoint,
  output logic [31:0] pos_demand,
  output logic [31:0] spd_demand,
  // ramp generator parameters
  output logic [31:0] accel_start_jerk,
  output logic [31:0] brake_start_jerk,
  output logic [31:0] accel_finish_jerk,
  output logic [31:0] brake_finish_jerk,
  output logic [JERK_PHASES-1:0] jerk_unlimited,
  output logic [31:0] jerk_factor_num,
  output logic [31:0] jerk_factor_den,
  output logic [31:0] pos_unit_word,
  output logic [31:0] vel_unit_word
);

  // ----------------------------------------------------------
  // helpers
  // ----------------------------------------------------------
  // word index of a byte address
  function automatic logic [IDX_W-1:0] reg_index(input logic [ADDR_W-1:0] a);
    return a[ADDR_W-1:2];
  endfunction

  // read-only entry count locations
  function automatic logic is_count(input logic [IDX_W-1:0] i);
    return (i == IDX_JF_COUNT) || (i == IDX_JL_COUNT);
  endfunction

  // byte-lane merge of a write into a stored word
  function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] d,
                                        input logic [3:0] strb);
    logic [31:0] r;
    r = old;
    for (int b = 0; b < 4; b++) begin
      if (strb[b]) begin
        r[8*b +: 8] = d[8*b +: 8];
      end
    end
    return r;
  endfunction

  // ----------------------------------------------------------
  // storage
  // ----------------------------------------------------------
  logic [31:0] jerk_lim_ff [JERK_PHASES];
  logic [JERK_PHASES-1:0] jerk_unlim_ff;
  logic [31:0] jf_top_ff, jf_bottom_ff, pos_unit_ff, vel_unit_ff;
  logic [31:0] pos_off_ff, spd_off_ff, pos_demand_ff, spd_demand_ff;

  // bus state
  logic awready_ff, wready_ff, aw_have_ff, w_have_ff, bvalid_ff, arready_ff, rvalid_ff;
  logic [IDX_W-1:0] widx_ff;
  logic [31:0] wdata_ff, rdata_ff;
  logic [3:0] wstrb_ff;
  logic [1:0] bresp_ff, rresp_ff;

  logic aw_hs, w_hs, ar_hs, do_wr, wr_known;
  logic nxt_aw_have, nxt_w_have, nxt_bvalid, nxt_rvalid;
  logic [31:0] nxt_rdata;
  logic [1:0] nxt_rresp;

  // ----------------------------------------------------------
  // write channel
  // ----------------------------------------------------------
  // handshakes and next-state of the write path
  assign aw_hs = s_axi_awvalid & awready_ff;
  assign w_hs = s_axi_wvalid & wready_ff;
  assign do_wr = aw_have_ff & w_have_ff & ~bvalid_ff;
  assign nxt_aw_have = (aw_have_ff | aw_hs) & ~do_wr;
  assign nxt_w_have = (w_have_ff | w_hs) & ~do_wr;
  assign nxt_bvalid = do_wr | (bvalid_ff & ~s_axi_bready);

  // address and data may arrive in either order
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      aw_have_ff <= 1'b0;
      w_have_ff <= 1'b0;
      awready_ff <= 1'b0;
      wready_ff <= 1'b0;
      widx_ff <= '0;
      wdata_ff <= '0;
      wstrb_ff <= '0;
    end else if (ce) begin
      aw_have_ff <= nxt_aw_have;
      w_have_ff <= nxt_w_have;
      awready_ff <= ~nxt_aw_have & ~nxt_bvalid;
      wready_ff <= ~nxt_w_have & ~nxt_bvalid;
      if (aw_hs) begin
        widx_ff <= reg_index(s_axi_awaddr);
      end
      if (w_hs) begin
        wdata_ff <= s_axi_wdata;
        wstrb_ff <= s_axi_wstrb;
      end
    end
  end

  // write hits a writable entry
  always_comb begin
    wr_known = 1'b0;
    case (widx_ff)
      IDX_POS_UNIT, IDX_VEL_UNIT, IDX_POS_OFF, IDX_SPD_OFF: wr_known = 1'b1;
      IDX_JF_TOP, IDX_JF_BOTTOM: wr_known = 1'b1;
      default: wr_known = (widx_ff >= IDX_JL_BASE) &&
                          (widx_ff < IDX_JL_BASE + JERK_PHASES);
    endcase
  end

  // write response; counts and holes answer slverr
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      bvalid_ff <= 1'b0;
      bresp_ff <= RESP_OKAY;
    end else if (ce) begin
      bvalid_ff <= nxt_bvalid;
      if (do_wr) begin
        bresp_ff <= wr_known ? RESP_OKAY : RESP_SLVERR;
      end
    end
  end

  // ----------------------------------------------------------
  // parameter registers
  // ----------------------------------------------------------
  // factor, unit words and offsets; reserved bits kept zero
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      jf_top_ff <= RST_FACTOR;
      jf_bottom_ff <= RST_FACTOR;
      pos_unit_ff <= RST_POS_UNIT;
      vel_unit_ff <= RST_VEL_UNIT;
      pos_off_ff <= RST_OFFSET;
      spd_off_ff <= RST_OFFSET;
    end else if (ce && do_wr) begin
      case (widx_ff)
        IDX_JF_TOP: jf_top_ff <= merge(jf_top_ff, wdata_ff, wstrb_ff);
        IDX_JF_BOTTOM: jf_bottom_ff <= merge(jf_bottom_ff, wdata_ff, wstrb_ff);
        IDX_POS_UNIT: pos_unit_ff <= merge(pos_unit_ff, wdata_ff, wstrb_ff)
                                     & POS_UNIT_MASK;
        IDX_VEL_UNIT: vel_unit_ff <= merge(vel_unit_ff, wdata_ff, wstrb_ff)
                                     & VEL_UNIT_MASK;
        IDX_POS_OFF: pos_off_ff <= merge(pos_off_ff, wdata_ff, wstrb_ff);
        IDX_SPD_OFF: spd_off_ff <= merge(spd_off_ff, wdata_ff, wstrb_ff);
        default: ;
      endcase
    end
  end

  // one jerk limit per ramp phase, with its unlimited flag
  generate
    for (genvar g = 0; g < JERK_PHASES; g++) begin : g_jerk
      always_ff @(posedge aclk) begin
        if (!aresetn) begin
          jerk_lim_ff[g] <= RST_JERK;
          jerk_unlim_ff[g] <= 1'b0;
        end else if (ce) begin
          if (do_wr && widx_ff == IDX_JL_BASE + g) begin
            jerk_lim_ff[g] <= merge(jerk_lim_ff[g], wdata_ff, wstrb_ff);
          end
          jerk_unlim_ff[g] <= (jerk_lim_ff[g] == 32'h00000000);
        end
      end
    end
  endgenerate

  // ----------------------------------------------------------
  // set value offsets
  // ----------------------------------------------------------
  // offsets only apply in the modes that use them
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      pos_demand_ff <= '0;
      spd_demand_ff <= '0;
    end else if (ce) begin
      pos_demand_ff <= (op_mode == MODE_CSP) ? pos_setpoint + pos_off_ff
                                             : pos_setpoint;
      spd_demand_ff <= (op_mode == MODE_CSP || op_mode == MODE_CSV ||
                        op_mode == MODE_CLKDIR) ? spd_setpoint + spd_off_ff
                                                : spd_setpoint;
    end
  end

  // ----------------------------------------------------------
  // read channel
  // ----------------------------------------------------------
  assign ar_hs = s_axi_arvalid & arready_ff;
  assign nxt_rvalid = ar_hs | (rvalid_ff & ~s_axi_rready);

  // read decode; holes read zero with slverr
  always_comb begin
    logic [IDX_W-1:0] ri;
    ri = reg_index(s_axi_araddr);
    nxt_rdata = 32'h00000000;
    nxt_rresp = RESP_OKAY;
    case (ri)
      IDX_POS_UNIT: nxt_rdata = pos_unit_ff;
      IDX_VEL_UNIT: nxt_rdata = vel_unit_ff;
      IDX_POS_OFF: nxt_rdata = pos_off_ff;
      IDX_SPD_OFF: nxt_rdata = spd_off_ff;
      IDX_JF_COUNT: nxt_rdata = {24'h000000, JF_ENTRIES};
      IDX_JF_TOP: nxt_rdata = jf_top_ff;
      IDX_JF_BOTTOM: nxt_rdata = jf_bottom_ff;
      IDX_JL_COUNT: nxt_rdata = {24'h000000, JL_ENTRIES};
      default: begin
        if (ri >= IDX_JL_BASE && ri < IDX_JL_BASE + JERK_PHASES) begin
          nxt_rdata = jerk_lim_ff[2'(ri - IDX_JL_BASE)];
        end else begin
          nxt_rresp = RESP_SLVERR;
        end
      end
    endcase
  end

  // one read under way; data held until taken
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      arready_ff <= 1'b0;
      rvalid_ff <= 1'b0;
      rdata_ff <= '0;
      rresp_ff <= RESP_OKAY;
    end else if (ce) begin
      arready_ff <= ~nxt_rvalid;
      rvalid_ff <= nxt_rvalid;
      if (ar_hs) begin
        rdata_ff <= nxt_rdata;
        rresp_ff <= nxt_rresp;
      end
    end
  end

  // ----------------------------------------------------------
  // outputs
  // ----------------------------------------------------------
  assign s_axi_awready = awready_ff;
  assign s_axi_wready = wready_ff;
  assign s_axi_bvalid = bvalid_ff;
  assign s_axi_bresp = bresp_ff;
  assign s_axi_arready = arready_ff;
  assign s_axi_rvalid = rvalid_ff;
  assign s_axi_rdata = rdata_ff;
  assign s_axi_rresp = rresp_ff;
  assign pos_demand = pos_demand_ff;
  assign spd_demand = spd_demand_ff;
  assign accel_start_jerk = jerk_lim_ff[0];
  assign brake_start_jerk = jerk_lim_ff[1];
  assign accel_finish_jerk = jerk_lim_ff[2];
  assign brake_finish_jerk = jerk_lim_ff[3];
  assign jerk_unlimited = jerk_unlim_ff;
  assign jerk_factor_num = jf_top_ff;
  assign jerk_factor_den = jf_bottom_ff;
  assign pos_unit_word = pos_unit_ff;
  assign vel_unit_word = vel_unit_ff;

  // ----------------------------------------------------------
  // checks
  // ----------------------------------------------------------
  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);

  // a read of a given index taken on an enabled edge
  sequence s_rd(logic [IDX_W-1:0] i);
    ce && ar_hs && reg_index(s_axi_araddr) == i;
  endsequence

  // a full-word write of a given index committed
  sequence s_wr(logic [IDX_W-1:0] i);
    ce && do_wr && widx_ff == i && wstrb_ff == 4'hF;
  endsequence

  property p_unlim;
    ce && jerk_lim_ff[0] == 32'h00000000 |=> jerk_unlimited[0];
  endproperty
  a_unlim: assert property (p_unlim) else $error("zero jerk not unlimited");

  property p_limited;
    ce && jerk_lim_ff[2] != 32'h00000000 |=> !jerk_unlimited[2];
  endproperty
  a_limited: assert property (p_limited) else $error("nonzero jerk unlimited");

  property p_jerk_wr;
    s_wr(IDX_JL_BASE) |=> accel_start_jerk == $past(wdata_ff)
                          ##1 !$past(ce) || jerk_unlimited[0] == (accel_start_jerk == 0);
  endproperty
  a_jerk_wr: assert property (p_jerk_wr) else $error("jerk write lost");

  property p_jl_count;
    s_rd(IDX_JL_COUNT) |=> s_axi_rvalid && s_axi_rdata == 32'h00000004;
  endproperty
  a_jl_count: assert property (p_jl_count) else $error("jerk count wrong");

  property p_jf_count;
    s_rd(IDX_JF_COUNT) |=> s_axi_rvalid && s_axi_rdata == 32'h00000002;
  endproperty
  a_jf_count: assert property (p_jf_count) else $error("factor count wrong");

  property p_pos_unit;
    s_wr(IDX_POS_UNIT) |=> pos_unit_word[15:0] == 16'h0000 &&
                           pos_unit_word[31:16] == $past(wdata_ff[31:16]);
  endproperty
  a_pos_unit: assert property (p_pos_unit) else $error("position unit word bad");

  property p_vel_unit;
    s_wr(IDX_VEL_UNIT) |=> vel_unit_word[7:0] == 8'h00 &&
                           vel_unit_word[31:8] == $past(wdata_ff[31:8]);
  endproperty
  a_vel_unit: assert property (p_vel_unit) else $error("velocity unit word bad");

  property p_pos_off;
    ce |=> pos_demand == $past(pos_setpoint) +
           (($past(op_mode) == MODE_CSP) ? $past(pos_off_ff) : 32'h00000000);
  endproperty
  a_pos_off: assert property (p_pos_off) else $error("position offset misapplied");

  property p_spd_off;
    ce && op_mode == MODE_CLKDIR |=> spd_demand == $past(spd_setpoint) + $past(spd_off_ff);
  endproperty
  a_spd_off: assert property (p_spd_off) else $error("speed offset missing");

  property p_cnt_wr;
    ce && do_wr && is_count(widx_ff) |=> s_axi_bvalid && s_axi_bresp == RESP_SLVERR;
  endproperty
  a_cnt_wr: assert property (p_cnt_wr) else $error("count write accepted");

endmodule

//--- verif/tb_top.sv
`timescale 1ns/1ps
module tb_top
  import mju_pkg::*;
  ;
  // ----------------------------------------------------------
  // signals
  // ----------------------------------------------------------
  typedef struct {logic [ADDR_W-1:0] a; logic [31:0] wd; logic [31:0] rd; logic [1:0] br;} mju_row_s;
  logic aclk = 1'b0;
  logic aresetn = 1'b0;
  logic ce = 1'b1;
  logic [ADDR_W-1:0] s_axi_awaddr, s_axi_araddr;
  logic s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready, s_axi_bvalid, s_axi_bready;
  logic s_axi_arvalid, s_axi_arready, s_axi_rvalid, s_axi_rready;
  logic [31:0] s_axi_wdata, s_axi_rdata, pos_setpoint, spd_setpoint, pos_demand, spd_demand;
  logic [3:0] s_axi_wstrb, jerk_unlimited;
  logic [1:0] s_axi_bresp, s_axi_rresp, resp;
  logic [7:0] op_mode;
  logic [31:0] accel_start_jerk, brake_start_jerk, accel_finish_jerk, brake_finish_jerk;
  logic [31:0] jerk_factor_num, jerk_factor_den, pos_unit_word, vel_unit_word, rd, exp_w;
  int bad_count = 0;
  int compares = 0;
  int cycles = 0;
  mju_row_s rows[12];
  logic [7:0] modes[5];

  // 200 MHz clock
  always #2.5 aclk = ~aclk;

  mju_param_bank dut (
    .aclk(aclk), .aresetn(aresetn), .ce(ce),
    .s_axi_awaddr(s_axi_awaddr), .s_axi_awprot(3'h0), .s_axi_awvalid(s_axi_awvalid),
    .s_axi_awready(s_axi_awready), .s_axi_wdata(s_axi_wdata), .s_axi_wstrb(s_axi_wstrb),
    .s_axi_wvalid(s_axi_wvalid), .s_axi_wready(s_axi_wready), .s_axi_bresp(s_axi_bresp),
    .s_axi_bvalid(s_axi_bvalid), .s_axi_bready(s_axi_bready), .s_axi_araddr(s_axi_araddr),
    .s_axi_arprot(3'h0), .s_axi_arvalid(s_axi_arvalid), .s_axi_arready(s_axi_arready),
    .s_axi_rdata(s_axi_rdata), .s_axi_rresp(s_axi_rresp), .s_axi_rvalid(s_axi_rvalid),
    .s_axi_rready(s_axi_rready), .op_mode(op_mode), .pos_setpoint(pos_setpoint),
    .spd_setpoint(spd_setpoint), .pos_demand(pos_demand), .spd_demand(spd_demand),
    .accel_start_jerk(accel_start_jerk), .brake_start_jerk(brake_start_jerk),
    .accel_finish_jerk(accel_finish_jerk), .brake_finish_jerk(brake_finish_jerk),
    .jerk_unlimited(jerk_unlimited), .jerk_factor_num(jerk_factor_num),
    .jerk_factor_den(jerk_factor_den), .pos_unit_word(pos_unit_word),
    .vel_unit_word(vel_unit_word)
  );

  // ----------------------------------------------------------
  // verdict and compare tasks
  // ----------------------------------------------------------
  task automatic end_sim;
    if (bad_count == 0 && compares > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask

  task automatic chk_word(input string name, input logic [31:0] e, input logic [31:0] g);
    compares++;
    if (g !== e) begin
      bad_count++;
      $display("ERROR %s expected %h seen %h", name, e, g);
    end
  endtask

  task automatic chk_resp(input string name, input logic [1:0] e, input logic [1:0] g);
    compares++;
    if (g !== e) begin
      bad_count++;
      $display("ERROR %s expected %h seen %h", name, e, g);
    end
  endtask

  // hang guard
  always @(posedge aclk) begin
    cycles <= cycles + 1;
    if (cycles == 5000) begin
      bad_count++;
      end_sim();
    end
  end

  // ----------------------------------------------------------
  // bus tasks
  // ----------------------------------------------------------
  task automatic axi_write(input logic [19:0] a, input logic [31:0] d, input logic [3:0] s,
                           output logic [1:0] r);
    logic aw, w;
    aw = 1'b1;
    w = 1'b1;
    s_axi_awaddr <= a;
    s_axi_awvalid <= 1'b1;
    s_axi_wdata <= d;
    s_axi_wstrb <= s;
    s_axi_wvalid <= 1'b1;
    s_axi_bready <= 1'b1;
    do begin
      @(posedge aclk);
      if (aw && s_axi_awready === 1'b1) begin
        aw = 1'b0;
        s_axi_awvalid <= 1'b0;
      end
      if (w && s_axi_wready === 1'b1) begin
        w = 1'b0;
        s_axi_wvalid <= 1'b0;
      end
    end while (s_axi_bvalid !== 1'b1);
    r = s_axi_bresp;
    s_axi_bready <= 1'b0;
    @(posedge aclk);
  endtask

  task automatic axi_read(input logic [19:0] a, output logic [31:0] d, output logic [1:0] r);
    logic ar;
    ar = 1'b1;
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    s_axi_rready <= 1'b1;
    do begin
      @(posedge aclk);
      if (ar && s_axi_arready === 1'b1) begin
        ar = 1'b0;
        s_axi_arvalid <= 1'b0;
      end
    end while (s_axi_rvalid !== 1'b1);
    d = s_axi_rdata;
    r = s_axi_rresp;
    s_axi_rready <= 1'b0;
    @(posedge aclk);
  endtask

  task automatic do_reset;
    @(posedge aclk);
    aresetn <= 1'b0;
    repeat (6) @(posedge aclk);
    aresetn <= 1'b1;
    @(posedge aclk);
  endtask

  // ----------------------------------------------------------
  // main sequence
  // ----------------------------------------------------------
  initial begin
    {s_axi_awaddr, s_axi_araddr, s_axi_wdata, s_axi_wstrb} = '0;
    {s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready} = '0;
    {op_mode, pos_setpoint, spd_setpoint} = '0;
    rows[0] = '{{IDX_POS_UNIT, 2'b00}, 32'h12345678, 32'h12340000, RESP_OKAY};
    rows[1] = '{{IDX_VEL_UNIT, 2'b00}, 32'h12345678, 32'h12345600, RESP_OKAY};
    rows[2] = '{{IDX_POS_OFF, 2'b00}, 32'h80000005, 32'h80000005, RESP_OKAY};
    rows[3] = '{{IDX_SPD_OFF, 2'b00}, 32'hFFFFFFF0, 32'hFFFFFFF0, RESP_OKAY};
    rows[4] = '{{IDX_JF_TOP, 2'b00}, 32'h0000000A, 32'h0000000A, RESP_OKAY};
    rows[5] = '{{IDX_JF_BOTTOM, 2'b00}, 32'h00000003, 32'h00000003, RESP_OKAY};
    rows[6] = '{{IDX_JL_BASE, 2'b00}, 32'h00000000, 32'h00000000, RESP_OKAY};
    rows[7] = '{{IDX_JL_BASE + 18'h1, 2'b00}, 32'h00000005, 32'h00000005, RESP_OKAY};
    rows[8] = '{{IDX_JL_BASE + 18'h2, 2'b00}, 32'h12345678, 32'h12345678, RESP_OKAY};
    rows[9] = '{{IDX_JL_BASE + 18'h3, 2'b00}, 32'hFFFFFFFF, 32'hFFFFFFFF, RESP_OKAY};
    rows[10] = '{{IDX_JF_COUNT, 2'b00}, 32'h000000FF, {24'h0, JF_ENTRIES}, RESP_SLVERR};
    rows[11] = '{{IDX_JL_COUNT, 2'b00}, 32'h000000FF, {24'h0, JL_ENTRIES}, RESP_SLVERR};
    modes = '{MODE_CSP, MODE_CSV, MODE_CLKDIR, 8'h01, 8'h00};
    do_reset();
    // write then read back every row, back to back
    for (int i = 0; i < 12; i++) begin
      axi_write(rows[i].a, rows[i].wd, 4'hF, resp);
      chk_resp("bresp", rows[i].br, resp);
      axi_read(rows[i].a, rd, resp);
      chk_resp("rresp", RESP_OKAY, resp);
      chk_word("rdata", rows[i].rd, rd);
    end
    // parameter outputs follow the written values
    chk_word("jerk_unlimited", 32'h1, {28'h0, jerk_unlimited});
    chk_word("accel_start_jerk", 32'h0, accel_start_jerk);
    chk_word("brake_start_jerk", 32'h5, brake_start_jerk);
    chk_word("accel_finish_jerk", 32'h12345678, accel_finish_jerk);
    chk_word("brake_finish_jerk", 32'hFFFFFFFF, brake_finish_jerk);
    chk_word("jerk_factor_num", 32'hA, jerk_factor_num);
    chk_word("jerk_factor_den", 32'h3, jerk_factor_den);
    chk_word("pos_unit_word", 32'h12340000, pos_unit_word);
    chk_word("vel_unit_word", 32'h12345600, vel_unit_word);
    // offsets applied only in their modes
    for (int i = 0; i < 5; i++) begin
      op_mode <= modes[i];
      pos_setpoint <= 32'h00000010 + i;
      spd_setpoint <= 32'h00000100;
      repeat (2) @(posedge aclk);
      exp_w = 32'h00000010 + i + ((modes[i] == MODE_CSP) ? 32'h80000005 : 32'h0);
      chk_word("pos_demand", exp_w, pos_demand);
      exp_w = (modes[i] inside {MODE_CSP, MODE_CSV, MODE_CLKDIR}) ? 32'hF0 : 32'h100;
      chk_word("spd_demand", exp_w, spd_demand);
    end
    // second reset restores every preset
    do_reset();
    chk_word("jerk_unlimited", 32'h0, {28'h0, jerk_unlimited});
    chk_word("brake_finish_jerk", RST_JERK, brake_finish_jerk);
    for (int i = 0; i < 12; i++) begin
      exp_w = (i < 4) ? ((i == 0) ? RST_POS_UNIT : (i == 1) ? RST_VEL_UNIT : RST_OFFSET) :
              (i < 6) ? RST_FACTOR : (i < 10) ? RST_JERK : rows[i].rd;
      axi_read(rows[i].a, rd, resp);
      chk_word("preset", exp_w, rd);
    end
    // single byte lane write keeps the other lanes
    axi_write(rows[6].a, 32'hAABBCCDD, 4'b0010, resp);
    axi_read(rows[6].a, rd, resp);
    chk_word("lane write", 32'h0000CCE8, rd);
    // unmapped index refused both ways
    axi_write({IDX_JL_BASE + 18'h4, 2'b00}, 32'h1, 4'hF, resp);
    chk_resp("unmapped bresp", RESP_SLVERR, resp);
    axi_read(20'h00000, rd, resp);
    chk_resp("unmapped rresp", RESP_SLVERR, resp);
    chk_word("unmapped rdata", 32'h0, rd);
    // clock enable low freezes the set value path
    ce <= 1'b0;
    pos_setpoint <= 32'h00000055;
    repeat (3) @(posedge aclk);
    chk_word("frozen pos_demand", 32'h00000014, pos_demand);
    ce <= 1'b1;
    repeat (2) @(posedge aclk);
    chk_word("pos_demand", 32'h00000055, pos_demand);
    end_sim();
  end
endmodule
